// >>> design/fpp_pkg.sv
// Package with offsets, field positions, reset values and carrier types of the protect/page block.
package fpp_pkg;
    // ==========================================================
    // Control-space offsets
    localparam logic [7:0] OFS_PAGE = 8'hE0;
    localparam logic [7:0] OFS_MAIN_LOCK = 8'hC0;
    localparam logic [7:0] OFS_SEC_LOCK = 8'hC2;
    // ==========================================================
    // Field layout and reset values
    localparam int SEC_SECURE_BIT = 7;
    localparam int SEC_LOCK_MSB = 3;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] CMD_RESET_FLASH = 8'hF0;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ABORT_TIME_US = 3;
    localparam int ABORT_CYCLES = (ABORT_TIME_US * 1000) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        FPP_IDLE    = 3'b000,
        FPP_PROGRAM = 3'b001,
        FPP_BULK    = 3'b010,
        FPP_SECTOR  = 3'b011,
        FPP_ABORT   = 3'b100
    } fpp_state_t;

    // Processor access into control or flash space.
    typedef struct packed {
        logic       ctl_sel;
        logic       flash_sel;
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fpp_bus_t;
endpackage

// >>> design/fpp_regs.sv
// Sector protection, security status, flash reset handling and page register.
`timescale 1ns/10ps
`default_nettype none

module fpp_regs #(
    parameter int ABORT_CNT = fpp_pkg::ABORT_CYCLES
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             ce,
    input  wire fpp_pkg::fpp_bus_t bus,
    input  wire logic [2:0]       flash_sector,
    input  wire logic             use_secondary,
    input  wire logic             req_program,
    input  wire logic             req_bulk,
    input  wire logic             req_sector,
    input  wire logic [7:0]       prog_data,
    input  wire logic [7:0]       stored_data,
    input  wire logic             op_done,
    input  wire logic             op_timeout,
    input  wire logic             ext_prog_req,
    input  wire logic             ext_lock_we,
    input  wire logic [7:0]       ext_main_lock,
    input  wire logic [3:0]       ext_sec_lock,
    input  wire logic             ext_secure_set,
    input  wire logic             ext_full_erase,
    output logic [7:0]            rdata,
    output logic                  op_start,
    output logic                  op_abort,
    output logic [7:0]            page_bits,
    output logic                  fault_flag,
    output logic                  busy,
    output logic                  ext_grant
);
    initial begin
        if (ABORT_CNT < 1 || ABORT_CNT > 65535) begin
            $error("ABORT_CNT out of range");
        end
    end

    // ==========================================================
    // Reset release
    logic rst_s1_q;
    logic rst_s2_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire rst_n = rst_s2_q;

    // ==========================================================
    // Pin synchronisers for the programmer port
    logic [14:0] ext_s1_q;
    logic [14:0] ext_s2_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_s1_q <= 15'h0000;
            ext_s2_q <= 15'h0000;
        end else if (ce) begin
            ext_s1_q <= {ext_prog_req, ext_lock_we, ext_main_lock, ext_sec_lock, ext_full_erase};
            ext_s2_q <= ext_s1_q;
        end
    end
    wire       x_req   = ext_s2_q[14];
    wire       x_we    = ext_s2_q[13];
    wire [7:0] x_main  = ext_s2_q[12:5];
    wire [3:0] x_sec   = ext_s2_q[4:1];
    wire       x_erase = ext_s2_q[0];
    logic xs_s1_q;
    logic xs_s2_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xs_s1_q <= 1'b0;
            xs_s2_q <= 1'b0;
        end else if (ce) begin
            xs_s1_q <= ext_secure_set;
            xs_s2_q <= xs_s1_q;
        end
    end

    // ==========================================================
    // Protection and security state
    logic [7:0] main_lock_q;
    logic [3:0] sec_lock_q;
    logic       secure_q;
    // Programmer is refused while secured, except for the full erase.
    wire x_allowed = !secure_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            main_lock_q <= 8'h00;
            sec_lock_q  <= 4'h0;
            secure_q    <= 1'b0;
        end else if (ce) begin
            if (x_erase) begin
                main_lock_q <= 8'h00;
                sec_lock_q  <= 4'h0;
                secure_q    <= 1'b0;
            end else if (x_we && x_allowed) begin
                main_lock_q <= x_main;
                sec_lock_q  <= x_sec;
                secure_q    <= secure_q | xs_s2_q;
            end
        end
    end

    // ==========================================================
    // Control-space decode
    wire ctl_wr   = bus.ctl_sel && bus.wr;
    wire page_wr  = ctl_wr && (bus.addr == fpp_pkg::OFS_PAGE);
    wire is_main  = bus.addr == fpp_pkg::OFS_MAIN_LOCK;
    wire is_sec   = bus.addr == fpp_pkg::OFS_SEC_LOCK;
    wire is_page  = bus.addr == fpp_pkg::OFS_PAGE;
    wire [7:0] main_status = main_lock_q;
    wire [7:0] sec_status  = {secure_q, 3'b000, sec_lock_q};
    wire [7:0] ctl_rdata   = is_main ? main_status :
                             is_sec  ? sec_status  :
                             is_page ? page_bits   : 8'h00;
    wire       tgt_locked  = use_secondary ? sec_lock_q[flash_sector[1:0]]
                                           : main_lock_q[flash_sector];
    // Processor flash reads pass regardless of the secure bit.
    wire [7:0] rd_next     = bus.ctl_sel ? ctl_rdata : stored_data;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            page_bits <= fpp_pkg::PAGE_RESET;
            rdata     <= 8'h00;
            ext_grant <= 1'b0;
        end else if (ce) begin
            if (page_wr) begin
                page_bits <= bus.wdata;
            end
            // Writes to the status offsets fall through untouched.
            if (bus.rd) begin
                rdata <= rd_next;
            end
            ext_grant <= x_req && x_allowed;
        end
    end

    // ==========================================================
    // Flash control machine
    fpp_pkg::fpp_state_t state_q;
    fpp_pkg::fpp_state_t state_d;
    logic [15:0] cnt_q;
    wire reset_cmd = bus.flash_sel && bus.wr && (bus.wdata == fpp_pkg::CMD_RESET_FLASH);
    wire bad_bits  = req_program && |(prog_data & ~stored_data);
    wire start_ok  = !tgt_locked || req_bulk;

    always_comb begin
        state_d = state_q;
        case (state_q)
            fpp_pkg::FPP_IDLE: begin
                if (start_ok && req_program && !bad_bits) begin
                    state_d = fpp_pkg::FPP_PROGRAM;
                end else if (req_bulk) begin
                    state_d = fpp_pkg::FPP_BULK;
                end else if (start_ok && req_sector) begin
                    state_d = fpp_pkg::FPP_SECTOR;
                end
            end
            fpp_pkg::FPP_PROGRAM, fpp_pkg::FPP_BULK: begin
                if (op_done || op_timeout) begin
                    state_d = fpp_pkg::FPP_IDLE;
                end
            end
            fpp_pkg::FPP_SECTOR: begin
                if (reset_cmd) begin
                    state_d = fpp_pkg::FPP_ABORT;
                end else if (op_done || op_timeout) begin
                    state_d = fpp_pkg::FPP_IDLE;
                end
            end
            fpp_pkg::FPP_ABORT: begin
                if (cnt_q == 16'h0000) begin
                    state_d = fpp_pkg::FPP_IDLE;
                end
            end
            default: state_d = fpp_pkg::FPP_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= fpp_pkg::FPP_IDLE;
            cnt_q      <= 16'h0000;
            fault_flag <= 1'b0;
            op_start   <= 1'b0;
            op_abort   <= 1'b0;
            busy       <= 1'b0;
        end else if (ce) begin
            state_q  <= state_d;
            op_start <= (state_q == fpp_pkg::FPP_IDLE) && (state_d != fpp_pkg::FPP_IDLE);
            op_abort <= (state_q == fpp_pkg::FPP_SECTOR) && (state_d == fpp_pkg::FPP_ABORT);
            busy     <= state_d != fpp_pkg::FPP_IDLE;
            if (state_d == fpp_pkg::FPP_ABORT && state_q != fpp_pkg::FPP_ABORT) begin
                cnt_q <= 16'(ABORT_CNT - 1);
            end else if (cnt_q != 16'h0000) begin
                cnt_q <= cnt_q - 16'h0001;
            end
            // Fault sets win over the reset command that clears it.
            if (bad_bits && state_q == fpp_pkg::FPP_IDLE && start_ok) begin
                fault_flag <= 1'b1;
            end else if (op_timeout && state_q != fpp_pkg::FPP_IDLE) begin
                fault_flag <= 1'b1;
            end else if (reset_cmd && (state_q == fpp_pkg::FPP_IDLE)) begin
                fault_flag <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// >>> sim/fpp_regs_asserts.sv
// Port checker for the protect/page block.
`timescale 1ns/10ps
`default_nettype none
module fpp_regs_asserts (
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              ce,
    input wire fpp_pkg::fpp_bus_t bus,
    input wire logic              req_program,
    input wire logic              req_bulk,
    input wire logic              req_sector,
    input wire logic [7:0]        rdata,
    input wire logic              op_start,
    input wire logic              op_abort,
    input wire logic [7:0]        page_bits,
    input wire logic              fault_flag,
    input wire logic              busy
);
    // ==========================================================
    // Decoded accesses
    wire pg_wr = ce && bus.ctl_sel && bus.wr && bus.addr == 8'hE0;
    wire rcmd  = ce && bus.flash_sel && bus.wr && bus.wdata == 8'hF0;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    page_load_a: assert property (pg_wr |=> page_bits == $past(bus.wdata))
        else $error("page bits not loaded from write data");
    page_keep_a: assert property (!pg_wr |=> $stable(page_bits))
        else $error("page bits changed without a write");
    page_clear_a: assert property (disable iff (1'b0) !rstn ##1 !rstn |-> page_bits == 8'h00)
        else $error("page bits not cleared in reset");
    page_read_a: assert property (ce && bus.ctl_sel && bus.rd && bus.addr == 8'hE0
        |=> rdata == $past(page_bits)) else $error("page readback wrong");
    start_cause_a: assert property (op_start |-> $past(req_program || req_bulk || req_sector))
        else $error("start without request");
    start_pulse_a: assert property (op_start |-> busy ##1 !op_start)
        else $error("start not a single pulse with busy");
    abort_cause_a: assert property (op_abort |-> $past(rcmd))
        else $error("abort without reset command");
    abort_done_a: assert property ($rose(op_abort) |-> ##[1:400] !busy)
        else $error("busy stuck after abort");
    fault_keep_a: assert property (fault_flag && !rcmd |=> fault_flag)
        else $error("fault flag dropped on its own");
    fault_clear_a: assert property (fault_flag && rcmd && !busy |=> !fault_flag)
        else $error("fault flag not cleared by reset command");
endmodule
bind fpp_regs fpp_regs_asserts u_chk (.clk(clk), .rstn(rstn), .ce(ce), .bus(bus),
    .req_program(req_program), .req_bulk(req_bulk), .req_sector(req_sector), .rdata(rdata),
    .op_start(op_start), .op_abort(op_abort), .page_bits(page_bits),
    .fault_flag(fault_flag), .busy(busy));
`default_nettype wire

// >>> sim/fpp_array_model.sv
// Array engine model that ends each started operation not cancelled by op_abort after a fixed delay.
`timescale 1ns/10ps
`default_nettype none
module fpp_array_model (
    input  wire logic clk,
    input  wire logic op_start,
    input  wire logic op_abort,
    input  wire logic tmo,
    output var logic  op_done,
    output var logic  op_timeout
);
    int cnt = 0;
    // The tmo input makes the current operation end in a timeout instead.
    always @(posedge clk) begin
        op_done <= cnt == 1 && !tmo;
        op_timeout <= cnt == 1 && tmo;
        if (op_start) begin
            cnt <= 6;
        end else if (op_abort) begin
            cnt <= 0;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule
`default_nettype wire

// >>> sim/test_flash_protect_page_regs.sv
// Self-checking bench for the protect/page block.
`timescale 1ns/10ps
`default_nettype none
module test_flash_protect_page_regs;
    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    fpp_pkg::fpp_bus_t b = '0;
    logic [2:0]        sct = '0;
    logic [7:0]        pd = '0, sd = 8'hFF, xm = '0, rdata, pg, d, ml;
    logic [3:0]        xs = '0;
    logic              sec = 0, rp = 0, rb = 0, rs = 0, tmo = 0, xp = 0, xw = 0, xset = 0;
    logic              xfe = 0, dn, to, st, ab, ff, bz, gr;
    logic [7:0]        q[$];
    int                n_mismatch = 0, tests_run = 0, cycles = 0;
    always #5 clk = ~clk;
    fpp_regs #(.ABORT_CNT(4)) dut (.clk(clk), .rstn(rstn), .ce(1'b1), .bus(b),
        .flash_sector(sct), .use_secondary(sec), .req_program(rp), .req_bulk(rb),
        .req_sector(rs), .prog_data(pd), .stored_data(sd), .op_done(dn), .op_timeout(to),
        .ext_prog_req(xp), .ext_lock_we(xw), .ext_main_lock(xm), .ext_sec_lock(xs),
        .ext_secure_set(xset), .ext_full_erase(xfe), .rdata(rdata), .op_start(st),
        .op_abort(ab), .page_bits(pg), .fault_flag(ff), .busy(bz), .ext_grant(gr));
    fpp_array_model u_arr (.clk(clk), .op_start(st), .op_abort(ab), .tmo(tmo),
        .op_done(dn), .op_timeout(to));
    // ==========================================================
    // Shared tasks
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (e !== g) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic acc(input logic c, input logic f, input logic w, input logic [7:0] a,
                       input logic [7:0] v);
        @(negedge clk);
        b = '{c, f, w, !w, a, v};
        @(negedge clk);
        b = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        q.push_back(e);
        acc(1, 0, 0, a, 8'h00);
    endtask
    task automatic req(input int k, input logic s, input logic [2:0] n, input logic e);
        @(negedge clk);
        {sec, sct} = {s, n};
        {rb, rs, rp} = 3'b001 << k;
        @(negedge clk);
        {rb, rs, rp} = 3'b000;
        chk("op_start", {7'h00, e}, {7'h00, st});
    endtask
    task automatic rcmd(input logic e);
        acc(0, 1, 1, 8'h00, 8'hF0);
        chk("op_abort", {7'h00, e}, {7'h00, ab});
    endtask
    task automatic idle;
        for (int i = 0; i < 50 && bz !== 1'b0; i++) @(negedge clk);
        chk("busy", 8'h00, {7'h00, bz});
    endtask
    task automatic ext(input int n);
        repeat (n) @(negedge clk);
        {xw, xset, xfe} = 3'b000;
        repeat (4) @(negedge clk);
    endtask
    task automatic conclude;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // The monitor takes the oldest expected read value one step after each read edge.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            conclude();
        end
        if (b.rd) begin
            #1;
            chk("rdata", q.pop_front(), rdata);
        end
    end
    initial begin
        d = 8'($urandom(86355));
        repeat (16) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        rd(8'hE0, 8'h00);
        chk("page_bits", 8'h00, pg);
        repeat (4) begin
            d = 8'($urandom);
            acc(1, 0, 1, 8'hE0, d);
            chk("page_bits", d, pg);
            rd(8'hE0, d);
        end
        ml = 8'h01 | (8'($urandom) & 8'hFC);
        {xm, xs, xw} = {ml, 4'h5, 1'b1};
        ext(4);
        rd(8'hC0, ml);
        rd(8'hC2, 8'h05);
        acc(1, 0, 1, 8'hC0, ~ml);
        acc(1, 0, 1, 8'hC2, 8'hFF);
        rd(8'hC0, ml);
        rd(8'hC2, 8'h05);
        q.push_back(8'hFF);
        acc(0, 1, 0, 8'h00, 8'h00);
        pd = 8'($urandom);
        req(0, 0, 3'h0, 0);
        req(1, 1, 3'h2, 0);
        req(0, 1, 3'h1, 1);
        rcmd(0);
        idle();
        req(2, 0, 3'h0, 1);
        rcmd(0);
        idle();
        req(1, 0, 3'h1, 1);
        rcmd(1);
        idle();
        sd = 8'h00;
        pd = 8'($urandom) | 8'h01;
        req(0, 0, 3'h1, 0);
        chk("fault_flag", 8'h01, {7'h00, ff});
        rcmd(0);
        chk("fault_flag", 8'h00, {7'h00, ff});
        {sd, tmo} = {8'hFF, 1'b1};
        req(0, 0, 3'h1, 1);
        idle();
        @(negedge clk);
        chk("fault_flag", 8'h01, {7'h00, ff});
        tmo = 1'b0;
        rcmd(0);
        chk("fault_flag", 8'h00, {7'h00, ff});
        {xp, xw, xset} = 3'b111;
        ext(4);
        chk("ext_grant", 8'h00, {7'h00, gr});
        rd(8'hC2, 8'h85);
        acc(1, 0, 1, 8'hC2, 8'h00);
        rd(8'hC2, 8'h85);
        req(0, 0, 3'h1, 1);
        idle();
        xfe = 1'b1;
        ext(4);
        chk("ext_grant", 8'h01, {7'h00, gr});
        rd(8'hC2, 8'h00);
        rd(8'hC0, 8'h00);
        repeat (3) @(negedge clk);
        conclude();
    end
endmodule
`default_nettype wire
